// ---- core/branch_pkg.sv ----
// shared constants, types and helpers for the branch and control decode block
package branch_pkg;

  // ---------------------------------------------------------------
  // instruction kinds delivered by the front end
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_BRANCH, OP_CALL_REL, OP_JUMP_REG, OP_CALL_REG,
    OP_ZERO_TEST, OP_NONZERO_TEST, OP_PREFIX, OP_BYTE_TABLE,
    OP_HALF_TABLE, OP_BREAKPOINT, OP_OTHER
  } op_t;

  // ---------------------------------------------------------------
  // condition codes, flags and sizes
  // ---------------------------------------------------------------
  localparam logic [3:0] COND_AL      = 4'hE;
  localparam int         FLAG_N       = 3;
  localparam int         FLAG_Z       = 2;
  localparam int         FLAG_C       = 1;
  localparam int         FLAG_V       = 0;
  localparam int         FAR_HI_BIT   = 24;  // +/-16 MB signed span
  localparam int         NEAR_HI_BIT  = 20;  // +/-1 MB signed span
  localparam int         BLOCK_MAX    = 4;
  localparam int         PRED_STATE_W = 11;
  localparam logic [31:0] WIDE_STEP   = 32'h0000_0004;
  localparam logic [31:0] NARROW_STEP = 32'h0000_0002;
  localparam logic [31:0] TABLE_GAP   = 32'h0000_0004;
  localparam logic [31:0] EVEN_MASK   = 32'hFFFF_FFFE;
  localparam logic [PRED_STATE_W-1:0] PRED_RESET = 11'h000;

  // flags are only read here, never produced
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic r;
    r = 1'b1;
    case (c[3:1])
      3'h0:    r = f[FLAG_Z];
      3'h1:    r = f[FLAG_C];
      3'h2:    r = f[FLAG_N];
      3'h3:    r = f[FLAG_V];
      3'h4:    r = f[FLAG_C] & ~f[FLAG_Z];
      3'h5:    r = f[FLAG_N] == f[FLAG_V];
      3'h6:    r = ~f[FLAG_Z] & (f[FLAG_N] == f[FLAG_V]);
      default: r = 1'b1;
    endcase
    cond_pass = (c[3:1] != 3'h7 && c[0]) ? ~r : r;
  endfunction

endpackage

// ---- core/pred_if.sv ----
// carrier between the decode core and the predicated block tracker
interface pred_if;
  import branch_pkg::*;
  logic                    start;
  logic [2:0]              len;
  logic [2:0]              else_bits;
  logic [3:0]              base_cond;
  logic                    advance;
  logic                    clear;
  logic                    restore;
  logic [PRED_STATE_W-1:0] restore_state;
  logic [PRED_STATE_W-1:0] state;
  logic                    active;
  logic [3:0]              cur_cond;

  modport tracker (input start, len, else_bits, base_cond, advance, clear, restore,
                   restore_state, output state, active, cur_cond);
  modport user    (output start, len, else_bits, base_cond, advance, clear, restore,
                   restore_state, input state, active, cur_cond);
endinterface

// ---- core/pred_tracker.sv ----
// predicated block tracker: base condition, then/else switches, remaining count
module pred_tracker
  import branch_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // core side
  pred_if.tracker   p
);

  logic [3:0] cond_q;
  logic [3:0] sw_q;    // bit 0 is the switch of the instruction now due
  logic [2:0] count_q;
  logic       active_q;  // kept as a flop so the block flag leaves the top registered

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // restore beats clear here, but the decode block gates restore off while exc_entry_in is high, so entry wins there
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {cond_q, sw_q, count_q} <= PRED_RESET;
      active_q <= 1'b0;
    end else if (p.restore) begin
      {cond_q, sw_q, count_q} <= p.restore_state;
      active_q <= p.restore_state[2:0] != 3'h0;
    end else if (p.clear) begin
      count_q  <= 3'h0;
      active_q <= 1'b0;
    end else if (p.start) begin
      cond_q   <= p.base_cond;
      sw_q     <= {p.else_bits, 1'b0};
      count_q  <= p.len;
      active_q <= p.len != 3'h0;
    end else if (p.advance && count_q != 3'h0) begin
      sw_q     <= {1'b0, sw_q[3:1]};
      count_q  <= count_q - 3'h1;
      active_q <= count_q != 3'h1;
    end
  end

  assign p.state    = {cond_q, sw_q, count_q};
  assign p.active   = active_q;
  assign p.cur_cond = sw_q[0] ? {cond_q[3:1], ~cond_q[0]} : cond_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start_else;
    p.start && !p.restore && !p.clear && p.len >= 3'h2 && p.else_bits[0];
  endsequence

  sequence s_plain_step;
    p.advance && !p.start && !p.clear && !p.restore;
  endsequence

  AST_ELSE_INVERTS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_start_else ##1 s_plain_step |=>
      p.cur_cond == ($past(p.base_cond, 2) ^ 4'h1))
    else $error("else switch did not invert the base condition");

  AST_FIRST_BASE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (p.start && !p.restore && !p.clear && p.len != 3'h0) |=>
      p.active && p.cur_cond == $past(p.base_cond))
    else $error("first instruction of block does not use base condition");

endmodule

// ---- core/branch_control_decode.sv ----
// branch, compare-and-branch, predication and table branch execute logic
module branch_control_decode
  import branch_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    sys_rst_in,
  // instruction issue
  input  wire logic                    issue_valid_in,
  input  wire op_t                     op_in,
  input  wire logic [3:0]              cond_in,
  input  wire logic                    wide_in,
  input  wire logic [31:0]             pc_in,
  input  wire logic [31:0]             offset_in,
  input  wire logic [31:0]             reg_a_in,
  input  wire logic [31:0]             reg_b_in,
  input  wire logic                    base_is_pc_in,
  input  wire logic [3:0]              flags_in,
  input  wire logic [2:0]              pred_len_in,
  input  wire logic [2:0]              pred_else_in,
  // exception entry and return
  input  wire logic                    exc_entry_in,
  input  wire logic                    exc_return_in,
  input  wire logic [PRED_STATE_W-1:0] exc_state_in,
  // table read port
  input  wire logic                    table_ack_in,
  input  wire logic [15:0]             table_data_in,
  // results
  output logic                         exec_out,
  output logic                         branch_out,
  output logic [31:0]                  target_out,
  output logic                         link_we_out,
  output logic [31:0]                  link_out,
  output logic                         fault_out,
  output logic                         range_err_out,
  output logic                         table_req_out,
  output logic [31:0]                  table_addr_out,
  output logic                         table_half_out,
  output logic [PRED_STATE_W-1:0]      exc_state_out,
  output logic                         in_block_out
);

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} state_t;

  pred_if p ();

  pred_tracker u_tracker (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .p          (p)
  );

  state_t      state_q,    state_d;
  logic        exec_q,     branch_q,   link_we_q, fault_q, range_q, req_q, half_q;
  logic [31:0] target_q,   link_q,     taddr_q,   tbase_q;
  logic [PRED_STATE_W-1:0] saved_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // issue is ignored while a table read is outstanding
  wire accept    = issue_valid_in && state_q == ST_IDLE && !exc_entry_in;
  wire in_blk    = p.active;
  wire is_rel    = op_in == OP_BRANCH || op_in == OP_CALL_REL;
  wire is_reg    = op_in == OP_JUMP_REG || op_in == OP_CALL_REG;
  wire is_test   = op_in == OP_ZERO_TEST || op_in == OP_NONZERO_TEST;
  wire is_table  = op_in == OP_BYTE_TABLE || op_in == OP_HALF_TABLE;
  // outside a block only the plain branch may carry a condition
  wire use_cond  = in_blk || op_in == OP_BRANCH;
  wire [3:0] eff_cond = in_blk ? p.cur_cond : cond_in;
  wire pass      = cond_pass(eff_cond, flags_in);
  wire go        = !use_cond || pass || op_in == OP_BREAKPOINT;

  wire near_lim  = op_in == OP_BRANCH && !in_blk && cond_in != COND_AL;
  wire fits_far  = &offset_in[31:FAR_HI_BIT] || ~|offset_in[31:FAR_HI_BIT];
  wire fits_near = &offset_in[31:NEAR_HI_BIT] || ~|offset_in[31:NEAR_HI_BIT];
  wire fits      = near_lim ? fits_near : fits_far;
  wire rel_ok    = is_rel && go && fits;
  wire rel_bad   = is_rel && go && !fits;

  wire reg_odd   = reg_a_in[0];
  wire reg_ok    = is_reg && go && reg_odd;
  wire reg_bad   = is_reg && go && !reg_odd;
  wire is_zero   = reg_a_in == 32'h0000_0000;
  // compare-only; flags are never written by this block
  wire test_tk   = (op_in == OP_ZERO_TEST && is_zero) ||
                   (op_in == OP_NONZERO_TEST && !is_zero);

  wire [31:0] next_pc   = pc_in + (wide_in ? WIDE_STEP : NARROW_STEP);
  wire [31:0] rel_tgt   = pc_in + offset_in;
  wire [31:0] reg_tgt   = reg_a_in & EVEN_MASK;
  wire [31:0] tbl_after = pc_in + TABLE_GAP;
  wire [31:0] tbl_base  = base_is_pc_in ? tbl_after : reg_a_in;
  wire [31:0] tbl_idx   = op_in == OP_HALF_TABLE ? {reg_b_in[30:0], 1'b0} : reg_b_in;
  wire [31:0] tbl_addr  = tbl_base + tbl_idx;
  wire [31:0] entry2    = half_q ? {15'h0000, table_data_in, 1'b0}
                                 : {23'h000000, table_data_in[7:0], 1'b0};
  wire [31:0] tbl_tgt   = tbase_q + entry2;
  wire        tbl_done  = state_q == ST_WAIT && table_ack_in && !exc_entry_in;
  wire        tbl_start = accept && is_table && go;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  wire        exec_d   = accept && op_in != OP_NONE && go;
  wire        branch_d = tbl_done ||
                         (accept && (rel_ok || reg_ok || (is_test && test_tk)));
  wire [31:0] target_d = tbl_done ? tbl_tgt : (is_reg ? reg_tgt : rel_tgt);
  wire        link_d   = accept && ((op_in == OP_CALL_REL && rel_ok) ||
                                    (op_in == OP_CALL_REG && reg_ok));
  wire        fault_d  = accept && reg_bad;
  wire        range_d  = accept && rel_bad;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (tbl_start) state_d = ST_WAIT;
      ST_WAIT: if (exc_entry_in || table_ack_in) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // tracker control
  // ---------------------------------------------------------------
  assign p.start         = accept && op_in == OP_PREFIX;
  assign p.len           = pred_len_in;
  assign p.else_bits     = pred_else_in;
  assign p.base_cond     = cond_in;
  assign p.advance       = accept && in_blk && op_in != OP_NONE;
  assign p.clear         = exc_entry_in;
  assign p.restore       = exc_return_in && !exc_entry_in;
  assign p.restore_state = exc_state_in;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      {exec_q, branch_q, link_we_q, fault_q, range_q} <= 5'h00;
      {req_q, half_q} <= 2'h0;
      {target_q, link_q, taddr_q, tbase_q} <= {4{32'h0000_0000}};
      saved_q <= PRED_RESET;
    end else begin
      state_q   <= state_d;
      exec_q    <= exec_d;
      branch_q  <= branch_d;
      target_q  <= branch_d ? target_d : target_q;
      link_we_q <= link_d;
      link_q    <= link_d ? next_pc : link_q;
      fault_q   <= fault_d;
      range_q   <= range_d;
      req_q     <= state_d == ST_WAIT;
      if (tbl_start) begin
        taddr_q <= tbl_addr;
        tbase_q <= tbl_after;
        half_q  <= op_in == OP_HALF_TABLE;
      end
      if (exc_entry_in) saved_q <= p.state;
    end
  end

  assign exec_out       = exec_q;
  assign branch_out     = branch_q;
  assign target_out     = target_q;
  assign link_we_out    = link_we_q;
  assign link_out       = link_q;
  assign fault_out      = fault_q;
  assign range_err_out  = range_q;
  assign table_req_out  = req_q;
  assign table_addr_out = taddr_q;
  assign table_half_out = half_q;
  assign exc_state_out  = saved_q;
  assign in_block_out   = p.active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_call_rel;
    accept && op_in == OP_CALL_REL && rel_ok;
  endsequence

  sequence s_prefix_two;
    accept && op_in == OP_PREFIX && pred_len_in == 3'h2 && !exc_return_in;
  endsequence

  AST_LINK_NEXT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_call_rel |=> link_we_out && branch_out && link_out == $past(next_pc))
    else $error("call did not write next address to link");

  AST_REG_FAULT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (accept && is_reg && go && !reg_a_in[0]) |=> fault_out && !branch_out && !link_we_out)
    else $error("even register target did not fault");

  AST_REG_EVEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (accept && is_reg && go && reg_a_in[0]) |=>
      branch_out && target_out == ($past(reg_a_in) & EVEN_MASK))
    else $error("register target bit0 not cleared");

  AST_NEAR_RANGE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (accept && near_lim && pass && !fits_near) |=> range_err_out && !branch_out)
    else $error("conditional branch beyond 1 MB was taken");

  AST_TEST_JUMP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (accept && is_test) |=> branch_out == $past(test_tk) && !fault_out)
    else $error("zero test jump decision wrong");

  AST_BREAKPOINT_TRAP_RUNS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (accept && op_in == OP_BREAKPOINT) |=> exec_out)
    else $error("breakpoint trap did not execute");

  AST_BLOCK_ENDS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    s_prefix_two ##1
      (accept && op_in != OP_NONE && op_in != OP_PREFIX && !exc_return_in)[*2] |=>
      !in_block_out)
    else $error("predicated block did not end after its length");

  AST_TABLE_ADDR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    tbl_start |=> table_req_out && table_addr_out == $past(tbl_addr))
    else $error("table read address wrong");

  AST_TABLE_JUMP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    tbl_done |=> branch_out && target_out == $past(tbl_tgt) && !table_req_out)
    else $error("table jump target wrong");

  AST_EXC_SAVE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    exc_entry_in |=> exc_state_out == $past(p.state) && !in_block_out)
    else $error("exception entry did not save block state");

endmodule

// ---- bench/table_mem_model.sv ----
// memory model that answers table entry reads of the branch block
module table_mem_model (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // table read port
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [3:0]  lat_in,
  output logic             ack_out,
  output logic [15:0]      data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt_q;
  logic       done_q;

  // -------------------------------------------------------------
  // responder
  // -------------------------------------------------------------
  // data toggles outside the ack cycle so a stale entry never matches
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q    <= 4'h0;
      done_q   <= 1'b0;
      ack_out  <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      ack_out  <= 1'b0;
      data_out <= ~data_out;
      if (!req_in) begin
        cnt_q  <= 4'h0;
        done_q <= 1'b0;
      end else if (!done_q && cnt_q == lat_in) begin
        ack_out  <= 1'b1;
        data_out <= addr_in[15:0] ^ 16'hC3A5;
        done_q   <= 1'b1;
      end else if (!done_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ---- bench/branch_control_decode_tb.sv ----
// self-checking bench for the branch and control decode block
module branch_control_decode_tb import branch_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_in = 0, sys_rst_in = 1, issue_valid_in = 0, wide_in = 1, base_is_pc_in = 0;
  op_t  op_in = OP_NONE;
  logic [3:0] cond_in = 4'hE, flags_in = 4'h0, lat = 4'h0;
  logic [31:0] pc_in = 0, offset_in = 0, reg_a_in = 0, reg_b_in = 0;
  logic [2:0] pred_len_in = 3'h1, pred_else_in = 3'h0;
  logic exc_entry_in = 0, exc_return_in = 0, table_ack_in;
  logic [PRED_STATE_W-1:0] exc_state_in = PRED_RESET, exc_state_out;
  logic [15:0] table_data_in;
  logic exec_out, branch_out, link_we_out, fault_out, range_err_out, table_req_out;
  logic table_half_out, in_block_out;
  logic [31:0] target_out, link_out, table_addr_out;
  int err_total = 0, comparisons = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  branch_control_decode branch_control_decode_inst (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid_in), .op_in(op_in),
    .cond_in(cond_in), .wide_in(wide_in), .pc_in(pc_in), .offset_in(offset_in),
    .reg_a_in(reg_a_in), .reg_b_in(reg_b_in), .base_is_pc_in(base_is_pc_in),
    .flags_in(flags_in), .pred_len_in(pred_len_in), .pred_else_in(pred_else_in),
    .exc_entry_in(exc_entry_in), .exc_return_in(exc_return_in), .exc_state_in(exc_state_in),
    .table_ack_in(table_ack_in), .table_data_in(table_data_in), .exec_out(exec_out),
    .branch_out(branch_out), .target_out(target_out), .link_we_out(link_we_out),
    .link_out(link_out), .fault_out(fault_out), .range_err_out(range_err_out),
    .table_req_out(table_req_out), .table_addr_out(table_addr_out),
    .table_half_out(table_half_out), .exc_state_out(exc_state_out),
    .in_block_out(in_block_out));

  table_mem_model table_mem_model_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .req_in(table_req_out), .addr_in(table_addr_out), .lat_in(lat),
    .ack_out(table_ack_in), .data_out(table_data_in));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  // request stays up across back-to-back issues; idle drops it at once, for the next edge
  task automatic issue(input op_t op, input logic [3:0] c, input logic [31:0] pc, off, a);
    issue_valid_in = 1;
    op_in = op;
    cond_in = c;
    pc_in = pc;
    offset_in = off;
    reg_a_in = a;
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic idle;
    issue_valid_in = 0;
    op_in = OP_NONE;
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic rel(input op_t op, input logic [3:0] c, input logic [31:0] off, input logic ok);
    issue(op, c, 32'h0100_0000, off, 0);
    chk({branch_out, range_err_out}, {ok, ~ok}, "relative range");
    if (ok) chk(target_out, 32'h0100_0000 + off, "relative target");
    if (op == OP_CALL_REL) chk(link_we_out, ok, "call link strobe");
    if (op == OP_CALL_REL) chk(link_out, 32'h0100_0004, "call link");
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_rel;
    rel(OP_CALL_REL, 4'hE, 32'h00FF_FFFE, 1);
    rel(OP_BRANCH, 4'hE, 32'hFF00_0000, 1);
    rel(OP_BRANCH, 4'hE, 32'h0100_0000, 0);
    rel(OP_CALL_REL, 4'hE, 32'hFEFF_FFFE, 0);
    flags_in = 4'h4;
    rel(OP_BRANCH, 4'h0, 32'hFFF0_0000, 1);
    rel(OP_BRANCH, 4'h0, 32'h0010_0000, 0);
    pred_len_in = 3'h1;
    issue(OP_PREFIX, 4'h0, 0, 0, 0);
    rel(OP_BRANCH, 4'h0, 32'h0010_0000, 1);
    chk(in_block_out, 0, "single block closed");
    flags_in = 4'h0;
    issue(OP_BRANCH, 4'h0, 32'h0000_0100, 32'h40, 0);
    chk({exec_out, branch_out, range_err_out}, 0, "failed condition");
    idle;
    $display("test relative done");
  endtask

  task automatic rj(input op_t op, input logic [31:0] a, input logic w, input logic flt);
    wide_in = w;
    issue(op, 4'hE, 32'h0000_0A00, 0, a);
    chk({branch_out, fault_out}, {~flt, flt}, "register jump fault");
    chk(link_we_out, (op == OP_CALL_REG) && !flt, "register link strobe");
    if (!flt) chk(target_out, a & 32'hFFFF_FFFE, "register target");
    if (!flt && op == OP_CALL_REG) chk(link_out, w ? 32'h0A04 : 32'h0A02, "link");
  endtask

  task automatic t_regjump;
    rj(OP_JUMP_REG, 32'h0000_2001, 1, 0);
    rj(OP_CALL_REG, 32'h0000_3005, 0, 0);
    rj(OP_CALL_REG, 32'hFFFF_FFFF, 1, 0);
    rj(OP_JUMP_REG, 32'h0000_2000, 1, 1);
    rj(OP_CALL_REG, 32'h0000_3004, 1, 1);
    idle;
    $display("test register jump done");
  endtask

  task automatic zt(input op_t op, input logic [31:0] a, off, input logic br);
    issue(op, 4'hE, 32'h0000_0C00, off, a);
    chk(branch_out, br, "test jump decision");
    if (br) chk(target_out, 32'h0000_0C00 + off, "test jump target");
  endtask

  task automatic t_tests;
    zt(OP_ZERO_TEST, 0, 32'h82, 1);
    zt(OP_ZERO_TEST, 1, 32'h04, 0);
    zt(OP_NONZERO_TEST, 32'h8000_0000, 32'h04, 1);
    zt(OP_NONZERO_TEST, 0, 32'h82, 0);
    idle;
    $display("test zero tests done");
  endtask

  task automatic t_block;
    logic [3:0] exp;
    exp = 4'b0101;
    flags_in = 4'h4;
    pred_len_in = 3'h4;
    pred_else_in = 3'b101;
    issue(OP_PREFIX, 4'h0, 0, 0, 0);
    chk(in_block_out, 1, "block open");
    for (int i = 0; i < 4; i++) begin
      issue(OP_OTHER, 4'h0, 0, 0, 0);
      chk(exec_out, exp[i], "then or else execution");
    end
    chk(in_block_out, 0, "block closed after four");
    flags_in = 4'h0;
    pred_len_in = 3'h2;
    pred_else_in = 3'h0;
    issue(OP_PREFIX, 4'h0, 0, 0, 0);
    issue(OP_OTHER, 4'h0, 0, 0, 0);
    chk(exec_out, 0, "failed block member");
    issue(OP_BREAKPOINT, 4'h0, 0, 0, 0);
    chk(exec_out, 1, "breakpoint executes");
    chk(in_block_out, 0, "block closed after two");
    idle;
    $display("test block done");
  endtask

  task automatic t_exc;
    pred_len_in = 3'h3;
    pred_else_in = 3'h0;
    issue(OP_PREFIX, 4'h1, 0, 0, 0);
    issue(OP_OTHER, 4'h1, 0, 0, 0);
    exc_entry_in = 1;
    issue(OP_BRANCH, 4'hE, 32'h100, 32'h40, 0);
    exc_entry_in = 0;
    chk({branch_out, in_block_out}, 0, "entry drops issue and block");
    chk(exc_state_out[2:0], 2, "saved remaining count");
    idle;
    exc_state_in = exc_state_out;
    exc_return_in = 1;
    @(posedge ref_clk_in);
    #1;
    exc_return_in = 0;
    chk(in_block_out, 1, "block resumed");
    for (int i = 0; i < 2; i++) begin
      issue(OP_OTHER, 4'h1, 0, 0, 0);
      chk(exec_out, 1, "resumed member");
    end
    chk(in_block_out, 0, "resumed block closed");
    idle;
    $display("test exception done");
  endtask

  task automatic tb1(input op_t op, input logic bpc, input logic [31:0] pc, a, b, adr,
                     input logic ab);
    logic [15:0] e;
    base_is_pc_in = bpc;
    reg_b_in = b;
    issue(op, 4'hE, pc, 0, a);
    chk({table_req_out, table_half_out}, {1'b1, op == OP_HALF_TABLE}, "table req");
    chk(table_addr_out, adr, "table address");
    idle;
    if (ab) exc_entry_in = 1;
    e = adr[15:0] ^ 16'hC3A5;
    if (op == OP_BYTE_TABLE) e = {8'h00, e[7:0]};
    for (int n = 0; n < 12 && branch_out !== 1; n++) begin
      @(posedge ref_clk_in);
      #1;
      exc_entry_in = 0;
    end
    chk({branch_out, table_req_out}, {~ab, 1'b0}, "table completion");
    if (!ab) chk(target_out, pc + 32'h4 + {15'h0, e, 1'b0}, "table target");
  endtask

  task automatic t_table;
    for (int l = 0; l < 4; l += 3) begin
      lat = l[3:0];
      tb1(OP_BYTE_TABLE, 0, 32'h0600, 32'h8000, 3, 32'h8003, 0);
      tb1(OP_HALF_TABLE, 1, 32'h4000, 0, 5, 32'h400E, 0);
    end
    tb1(OP_BYTE_TABLE, 0, 32'h0600, 32'h8000, 7, 32'h8007, 1);
    $display("test table done");
  endtask

  // -------------------------------------------------------------
  // run control
  // -------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    complete_run;
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    #1;
    sys_rst_in = 0;
    t_rel;
    t_regjump;
    t_tests;
    t_block;
    t_exc;
    t_table;
    complete_run;
  end
endmodule
